/* core/overcurrent_pickup.v */
// phase overcurrent stage: pick-up, blocking, forcing and readouts
// How it works
// - pick-up when any phase exceeds threshold
// - release below 97 percent of threshold
// - start only while blocking inactive
// - unblocked pick-up asserts start, starts timing
// - blocking sampled first each program cycle
// - blocked pick-up asserts blocked, stops processing
// - late blocking drops start, release follows
// - blocking rising during pick-up emits event and display notice
// - inrush blocking option, default off
// - inrush uses second harmonic percent limit
// - magnitude select: rms, true rms, peak
// - force status overrides outputs by code
// - forcing only in stage forcing mode
// - forcing mode lets switch drive blocking
// - comm bus may change threshold, code 2
// - overall condition code reported
// - per-phase condition code reported
// - remaining trip time in 5 ms steps
// - highest current to threshold ratio
// - inverse time follows highest current
// - static settings ignore group switching
`timescale 1ns/1ps
`default_nettype none
`include "oc_stage_map.vh"

module overcurrent_pickup #(
  parameter MAG_W = 16,
  parameter TIME_W = 19,
  parameter RAT_W = 16,
  parameter PROG_CYCLE_CLKS = `OC_PROG_CYCLE_CLKS
) (
  input wire clk,
  input wire rst_n,
  input wire block_pin,
  input wire sw_block_switch,
  input wire stage_forcing_en,
  input wire static_wr,
  input wire [1:0] comm_ctrl_set,
  input wire [4:0] force_status_set,
  input wire [1:0] mag_select_set,
  input wire group_wr,
  input wire [MAG_W-1:0] group_threshold,
  input wire remote_wr,
  input wire [MAG_W-1:0] remote_threshold,
  input wire inrush_en,
  input wire [MAG_W-1:0] harm_limit,
  input wire [MAG_W-1:0] second_harmonic_fraction,
  input wire idmt_mode,
  input wire [TIME_W-1:0] idmt_k,
  input wire [TIME_W-1:0] op_delay,
  input wire [TIME_W-1:0] release_time,
  input wire [MAG_W-1:0] phase1_rms_current,
  input wire [MAG_W-1:0] phase2_rms_current,
  input wire [MAG_W-1:0] phase3_rms_current,
  input wire [MAG_W-1:0] phase1_true_rms_magnitude,
  input wire [MAG_W-1:0] phase2_true_rms_magnitude,
  input wire [MAG_W-1:0] phase3_true_rms_magnitude,
  input wire [MAG_W-1:0] phase1_peak_magnitude,
  input wire [MAG_W-1:0] phase2_peak_magnitude,
  input wire [MAG_W-1:0] phase3_peak_magnitude,
  output reg start_q,
  output reg trip_q,
  output reg blocked_q,
  output reg [2:0] phase_start_q,
  output reg [2:0] phase_trip_q,
  output reg [1:0] stage_condition_q,
  output reg [3:0] phases_condition_q,
  output reg [TIME_W-1:0] time_to_trip_q,
  output reg [TIME_W-1:0] expected_time_q,
  output reg [RAT_W-1:0] highest_phase_to_threshold_ratio_q,
  output reg [MAG_W-1:0] pickup_threshold_q,
  output reg block_event_q,
  output reg hmi_notify_q,
  output reg [MAG_W-1:0] event_current_a_q,
  output reg [MAG_W-1:0] event_current_b_q,
  output reg [MAG_W-1:0] event_current_c_q,
  output reg [2:0] event_fault_type_q
);

  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_TRIP = 3'h2;
  localparam ST_BLK = 3'h3;
  localparam ST_REL = 3'h4;
  localparam CW = $clog2(PROG_CYCLE_CLKS);
  localparam [CW-1:0] TICK_LAST = PROG_CYCLE_CLKS[CW-1:0] - 1'b1;
  localparam [TIME_W-1:0] TIME_MAX = {TIME_W{1'b1}};
  localparam [RAT_W-1:0] RAT_ONE = 16'h0064;

  // per-phase condition code from a phase mask
  function [3:0] phase_code;
    input [2:0] mask;
    input is_trip;
    reg [3:0] base;
    begin
      base = 4'h0;
      case (mask)
        3'b001: base = 4'h1;
        3'b010: base = 4'h2;
        3'b100: base = 4'h3;
        3'b011: base = 4'h7;
        3'b110: base = 4'h8;
        3'b101: base = 4'h9;
        3'b111: base = 4'hA;
        default: base = 4'h0;
      endcase
      if (base == 4'h0)
        phase_code = 4'h0;
      else if (!is_trip)
        phase_code = base;
      else if (base < 4'h7)
        phase_code = base + 4'h3;
      else
        phase_code = base + 4'h4;
    end
  endfunction

  // phase mask of a forced status code
  function [2:0] force_mask;
    input [4:0] code;
    begin
      case (code)
        5'h04, 5'h07: force_mask = 3'b001;
        5'h05, 5'h08: force_mask = 3'b010;
        5'h06, 5'h09: force_mask = 3'b100;
        5'h0A, 5'h0E: force_mask = 3'b011;
        5'h0B, 5'h0F: force_mask = 3'b110;
        5'h0C, 5'h10: force_mask = 3'b101;
        5'h0D, 5'h11: force_mask = 3'b111;
        default: force_mask = 3'b000;
      endcase
    end
  endfunction

  // ****************************************
  // program cycle divider
  // ****************************************
  reg [CW-1:0] cnt_q;
  reg tick_q;
  reg stg_tick_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= {CW{1'b0}};
      tick_q <= 1'b0;
      stg_tick_q <= 1'b0;
    end else begin
      tick_q <= (cnt_q == TICK_LAST);
      cnt_q <= (cnt_q == TICK_LAST) ? {CW{1'b0}} : cnt_q + 1'b1;
      stg_tick_q <= tick_q;
    end
  end

  // ****************************************
  // blocking pin filter
  // ****************************************
  reg blk_s1_q, blk_s2_q, blk_s3_q, blk_filt_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      blk_s1_q <= 1'b0;
      blk_s2_q <= 1'b0;
      blk_s3_q <= 1'b0;
      blk_filt_q <= 1'b0;
    end else begin
      blk_s1_q <= block_pin;
      blk_s2_q <= blk_s1_q;
      blk_s3_q <= blk_s2_q;
      if (blk_s2_q == blk_s3_q)
        blk_filt_q <= blk_s3_q;
    end
  end

  // ****************************************
  // settings
  // ****************************************
  reg [1:0] comm_ctrl_q, mag_sel_q;
  reg [4:0] force_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      comm_ctrl_q <= `OC_COMM_RST;
      mag_sel_q <= `OC_MAGSEL_RST;
      force_q <= `OC_FORCE_RST;
      pickup_threshold_q <= `OC_THRESHOLD_RST;
    end else begin
      if (static_wr) begin
        comm_ctrl_q <= comm_ctrl_set;
        mag_sel_q <= mag_select_set;
        force_q <= force_status_set;
      end
      if (remote_wr && comm_ctrl_q == `OC_COMM_ALLOWED)
        pickup_threshold_q <= remote_threshold;
      else if (group_wr)
        pickup_threshold_q <= group_threshold;
    end
  end

  // ****************************************
  // phase comparators
  // ****************************************
  wire [3*MAG_W-1:0] rms_bus = {phase3_rms_current, phase2_rms_current,
                                phase1_rms_current};
  wire [3*MAG_W-1:0] true_rms_bus = {phase3_true_rms_magnitude,
                                 phase2_true_rms_magnitude,
                                 phase1_true_rms_magnitude};
  wire [3*MAG_W-1:0] pp_bus = {phase3_peak_magnitude, phase2_peak_magnitude,
                               phase1_peak_magnitude};
  wire [3*MAG_W-1:0] mag_bus;
  wire [2:0] pu_mask;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_phase
      phase_pickup #(.MAG_W(MAG_W)) u_pu (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick_q),
        .mag_select(mag_sel_q),
        .rms(rms_bus[g*MAG_W +: MAG_W]),
        .true_rms(true_rms_bus[g*MAG_W +: MAG_W]),
        .peak(pp_bus[g*MAG_W +: MAG_W]),
        .threshold(pickup_threshold_q),
        .measured_phase_magnitude(mag_bus[g*MAG_W +: MAG_W]),
        .pickup_q(pu_mask[g])
      );
    end
  endgenerate
  wire any_pu = |pu_mask;

  // ****************************************
  // highest phase, ratio, expected time
  // ****************************************
  wire [MAG_W-1:0] mag_a = mag_bus[MAG_W-1:0];
  wire [MAG_W-1:0] mag_b = mag_bus[2*MAG_W-1:MAG_W];
  wire [MAG_W-1:0] mag_c = mag_bus[3*MAG_W-1:2*MAG_W];
  wire [MAG_W-1:0] max_ab = (mag_a > mag_b) ? mag_a : mag_b;
  wire [MAG_W-1:0] max_abc = (max_ab > mag_c) ? max_ab : mag_c;
  wire [MAG_W+6:0] max_x100 = max_abc * `OC_PCT_SCALE;
  wire [MAG_W+6:0] thr_ext = {7'h00, pickup_threshold_q};
  // zero threshold would divide by zero, read as saturated
  wire [MAG_W+6:0] ratio_full = (pickup_threshold_q == {MAG_W{1'b0}}) ?
                                {(MAG_W+7){1'b1}} : max_x100 / thr_ext;
  wire [RAT_W-1:0] ratio_now = (|ratio_full[MAG_W+6:RAT_W]) ?
                               {RAT_W{1'b1}} : ratio_full[RAT_W-1:0];
  wire [TIME_W+6:0] k_x100 = idmt_k * `OC_PCT_SCALE;
  wire [TIME_W+6:0] excess = {{(TIME_W+7-RAT_W){1'b0}}, ratio_now - RAT_ONE};
  wire [TIME_W+6:0] inv_full = k_x100 / excess;
  reg [TIME_W-1:0] exp_now;
  always @* begin
    if (!idmt_mode)
      exp_now = op_delay;
    else if (ratio_now <= RAT_ONE || |inv_full[TIME_W+6:TIME_W])
      exp_now = TIME_MAX;
    else
      exp_now = inv_full[TIME_W-1:0];
  end

  // ****************************************
  // blocking condition
  // ****************************************
  // switch drives blocking in stage forcing mode, filtered pin otherwise
  wire ext_blk = stage_forcing_en ? sw_block_switch : blk_filt_q;
  wire inrush_blk = inrush_en && (second_harmonic_fraction >= harm_limit);
  wire blk_now = ext_blk | inrush_blk;

  // ****************************************
  // stage state machine
  // ****************************************
  reg [2:0] st_q;
  reg [TIME_W-1:0] timer_q, rel_cnt_q;
  reg blk_q;
  always @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      timer_q <= {TIME_W{1'b0}};
      rel_cnt_q <= {TIME_W{1'b0}};
      blk_q <= 1'b0;
    end else if (stg_tick_q) begin
      blk_q <= blk_now;
      case (st_q)
        ST_IDLE: begin
          rel_cnt_q <= {TIME_W{1'b0}};
          if (any_pu && blk_now) begin
            st_q <= ST_BLK;
          end else if (any_pu) begin
            st_q <= ST_START;
            timer_q <= exp_now;
          end
        end
        ST_START: begin
          if (blk_now || !any_pu) begin
            st_q <= ST_REL;
            rel_cnt_q <= {TIME_W{1'b0}};
          end else if (timer_q <= {{(TIME_W-1){1'b0}}, 1'b1}) begin
            st_q <= ST_TRIP;
            timer_q <= {TIME_W{1'b0}};
          end else begin
            timer_q <= timer_q - 1'b1;
          end
        end
        ST_REL: begin
          // timer held while the release time runs
          if (any_pu && !blk_now) begin
            st_q <= ST_START;
          end else if (rel_cnt_q >= release_time) begin
            st_q <= ST_IDLE;
            timer_q <= {TIME_W{1'b0}};
          end else begin
            rel_cnt_q <= rel_cnt_q + 1'b1;
          end
        end
        ST_TRIP: begin
          if (!any_pu || blk_now) begin
            st_q <= ST_IDLE;
          end
        end
        ST_BLK: begin
          if (!any_pu)
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  wire run_start = (st_q == ST_START);
  wire run_trip = (st_q == ST_TRIP);
  wire run_blk = (st_q == ST_BLK) || (!run_start && !run_trip &&
                 blk_q && any_pu);
  wire [2:0] f_mask = force_mask(force_q);
  wire f_trip = (force_q == `OC_FORCE_TRIP) ||
                (force_q >= 5'h07 && force_q <= 5'h09) ||
                (force_q >= 5'h0E);
  wire f_start = !f_trip && force_q != `OC_FORCE_NORMAL &&
                 force_q != `OC_FORCE_BLOCKED;
  wire forced = stage_forcing_en && force_q != `OC_FORCE_NORMAL;

  always @(posedge clk) begin
    if (!rst_n) begin
      start_q <= 1'b0;
      trip_q <= 1'b0;
      blocked_q <= 1'b0;
      phase_start_q <= 3'h0;
      phase_trip_q <= 3'h0;
      stage_condition_q <= `OC_COND_NORMAL;
      phases_condition_q <= 4'h0;
      time_to_trip_q <= {TIME_W{1'b0}};
      expected_time_q <= {TIME_W{1'b0}};
      highest_phase_to_threshold_ratio_q <= {RAT_W{1'b0}};
      block_event_q <= 1'b0;
      hmi_notify_q <= 1'b0;
      event_current_a_q <= {MAG_W{1'b0}};
      event_current_b_q <= {MAG_W{1'b0}};
      event_current_c_q <= {MAG_W{1'b0}};
      event_fault_type_q <= 3'h0;
    end else begin
      block_event_q <= 1'b0;
      hmi_notify_q <= 1'b0;
      if (stg_tick_q) begin
        highest_phase_to_threshold_ratio_q <= ratio_now;
        expected_time_q <= exp_now;
        time_to_trip_q <= run_start ? timer_q : {TIME_W{1'b0}};
        if (blk_now && !blk_q && any_pu) begin
          block_event_q <= 1'b1;
          hmi_notify_q <= 1'b1;
          event_current_a_q <= mag_a;
          event_current_b_q <= mag_b;
          event_current_c_q <= mag_c;
          event_fault_type_q <= pu_mask;
        end
        if (forced) begin
          start_q <= f_start;
          trip_q <= f_trip;
          blocked_q <= (force_q == `OC_FORCE_BLOCKED);
          phase_start_q <= f_trip ? 3'h0 : f_mask;
          phase_trip_q <= f_trip ? f_mask : 3'h0;
          phases_condition_q <= phase_code(f_mask, f_trip);
          stage_condition_q <= f_trip ? `OC_COND_TRIP :
                               f_start ? `OC_COND_START :
                               (force_q == `OC_FORCE_BLOCKED) ?
                               `OC_COND_BLOCKED : `OC_COND_NORMAL;
        end else begin
          start_q <= run_start;
          trip_q <= run_trip;
          blocked_q <= run_blk;
          phase_start_q <= run_start ? pu_mask : 3'h0;
          phase_trip_q <= run_trip ? pu_mask : 3'h0;
          phases_condition_q <= (run_start || run_trip) ?
                                phase_code(pu_mask, run_trip) : 4'h0;
          stage_condition_q <= run_trip ? `OC_COND_TRIP :
                               run_start ? `OC_COND_START :
                               run_blk ? `OC_COND_BLOCKED : `OC_COND_NORMAL;
        end
      end
    end
  end

endmodule // overcurrent_pickup
`default_nettype wire

/* core/oc_stage_map.vh */
// constants of the phase overcurrent pick-up stage
`ifndef OC_STAGE_MAP_VH
`define OC_STAGE_MAP_VH

// ****************************************
// timing
// ****************************************
`define OC_CLK_PERIOD_NS 5
`define OC_PROG_CYCLE_NS 5000000
`define OC_PROG_CYCLE_CLKS (`OC_PROG_CYCLE_NS / `OC_CLK_PERIOD_NS)
`define OC_BLOCK_MARGIN_NS 5000000

// ****************************************
// pick-up arithmetic
// ****************************************
`define OC_RESET_PCT 7'h61
`define OC_PCT_SCALE 7'h64

// ****************************************
// setting codes and reset values
// ****************************************
`define OC_MAG_RMS 2'h1
`define OC_MAG_TRUE_RMS 2'h2
`define OC_MAG_PP 2'h3
`define OC_COMM_DISABLED 2'h1
`define OC_COMM_ALLOWED 2'h2
`define OC_FORCE_NORMAL 5'h00
`define OC_FORCE_START 5'h01
`define OC_FORCE_TRIP 5'h02
`define OC_FORCE_BLOCKED 5'h03
`define OC_MAGSEL_RST `OC_MAG_RMS
`define OC_COMM_RST `OC_COMM_DISABLED
`define OC_FORCE_RST `OC_FORCE_NORMAL
`define OC_THRESHOLD_RST 16'h0078

// ****************************************
// condition codes
// ****************************************
`define OC_COND_NORMAL 2'h0
`define OC_COND_START 2'h1
`define OC_COND_TRIP 2'h2
`define OC_COND_BLOCKED 2'h3

`endif

/* core/phase_pickup.v */
// one phase: magnitude select and pick-up comparator with hysteresis
`timescale 1ns/1ps
`default_nettype none
`include "oc_stage_map.vh"

module phase_pickup #(
  parameter MAG_W = 16
) (
  input wire clk,
  input wire rst_n,
  input wire tick,
  input wire [1:0] mag_select,
  input wire [MAG_W-1:0] rms,
  input wire [MAG_W-1:0] true_rms,
  input wire [MAG_W-1:0] peak,
  input wire [MAG_W-1:0] threshold,
  output wire [MAG_W-1:0] measured_phase_magnitude,
  output reg pickup_q
);

  // ****************************************
  // magnitude select
  // ****************************************
  reg [MAG_W-1:0] sel;
  always @* begin
    case (mag_select)
      `OC_MAG_TRUE_RMS: sel = true_rms;
      `OC_MAG_PP: sel = peak;
      default: sel = rms;
    endcase
  end
  assign measured_phase_magnitude = sel;

  // ****************************************
  // comparator
  // ****************************************
  // scaled products avoid a divider for the release level
  wire [MAG_W+6:0] mag_x100 = sel * `OC_PCT_SCALE;
  wire [MAG_W+6:0] thr_x97 = threshold * `OC_RESET_PCT;

  always @(posedge clk) begin
    if (!rst_n) begin
      pickup_q <= 1'b0;
    end else if (tick) begin
      if (sel > threshold) begin
        pickup_q <= 1'b1;
      end else if (mag_x100 < thr_x97) begin
        pickup_q <= 1'b0;
      end
    end
  end

endmodule // phase_pickup
`default_nettype wire

/* dv/oc_stage_monitor.sv */
// port checker of the phase overcurrent pick-up stage
`timescale 1ns/1ps
`default_nettype none
module oc_stage_monitor #(
  parameter MAG_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic group_wr,
  input wire logic remote_wr,
  input wire logic start_q,
  input wire logic trip_q,
  input wire logic blocked_q,
  input wire logic [2:0] phase_start_q,
  input wire logic [2:0] phase_trip_q,
  input wire logic [1:0] stage_condition_q,
  input wire logic [3:0] phases_condition_q,
  input wire logic [MAG_W-1:0] pickup_threshold_q,
  input wire logic block_event_q,
  input wire logic hmi_notify_q
);
  // ****************************************
  // sequences and properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_block_pulse;
    block_event_q ##1 !block_event_q;
  endsequence
  sequence s_threshold_cause;
    $past(group_wr) || $past(remote_wr);
  endsequence
  a_start_not_blocked: assert property (start_q |-> !blocked_q)
    else $error("start and blocked together");
  a_blocked_cond: assert property (blocked_q |-> stage_condition_q == 2'h3)
    else $error("blocked without condition 3");
  a_trip_cond: assert property (trip_q |-> stage_condition_q == 2'h2)
    else $error("trip without condition 2");
  a_phase_trip_code: assert property (phase_trip_q == 3'h7 |-> phases_condition_q == 4'hE)
    else $error("three phase trip code wrong");
  a_phase_start_code: assert property ((phase_start_q == 3'h7 && phase_trip_q == 3'h0)
    |-> phases_condition_q == 4'hA)
    else $error("three phase start code wrong");
  a_event_pulse: assert property (block_event_q |-> s_block_pulse)
    else $error("block event not one clock");
  a_event_notify: assert property (block_event_q |-> hmi_notify_q)
    else $error("block event without display notice");
  a_cond_stands: assert property ($changed(stage_condition_q)
    |=> $stable(stage_condition_q)[*6])
    else $error("condition changed within a program cycle");
  a_threshold_cause: assert property ($changed(pickup_threshold_q) |-> s_threshold_cause)
    else $error("threshold changed without a write");
  a_reset_values: assert property ($rose(rst_n) |-> (!start_q && !trip_q && !blocked_q
    && stage_condition_q == 2'h0 && pickup_threshold_q == 16'h0078))
    else $error("outputs not at reset values");
endmodule // oc_stage_monitor

bind overcurrent_pickup oc_stage_monitor #(.MAG_W(MAG_W)) mon_u (.clk(clk),
  .rst_n(rst_n), .group_wr(group_wr), .remote_wr(remote_wr), .start_q(start_q),
  .trip_q(trip_q), .blocked_q(blocked_q), .phase_start_q(phase_start_q),
  .phase_trip_q(phase_trip_q), .stage_condition_q(stage_condition_q),
  .phases_condition_q(phases_condition_q),
  .pickup_threshold_q(pickup_threshold_q), .block_event_q(block_event_q),
  .hmi_notify_q(hmi_notify_q));
`default_nettype wire

/* dv/meas_chain_model.sv */
// measurement chain and blocking source in front of the stage
`timescale 1ns/1ps
`default_nettype none
module meas_chain_model #(
  parameter int REFRESH = 8
) (
  input wire logic clk,
  input wire logic [47:0] rms_set,
  input wire logic [47:0] true_set,
  input wire logic [47:0] peak_set,
  input wire logic block_req,
  output logic [47:0] rms_o,
  output logic [47:0] true_o,
  output logic [47:0] peak_o,
  output logic block_pin
);
  int cnt;
  initial begin
    cnt = 0;
    rms_o = '0;
    true_o = '0;
    peak_o = '0;
    block_pin = 1'b0;
  end
  always @(negedge clk) begin
    cnt <= (cnt == REFRESH - 1) ? 0 : cnt + 1;
    if (cnt == 0) begin
      rms_o <= rms_set;
      true_o <= true_set;
      peak_o <= peak_set;
    end
  end
  always @(negedge clk) begin
    block_pin <= block_req;
  end
endmodule // meas_chain_model
`default_nettype wire

/* dv/test_overcurrent_pickup.sv */
// self-checking bench of the phase overcurrent pick-up stage
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t ns: got %0h expected %0h", $time, g, e); end end
module test_overcurrent_pickup;
  logic clk, rst_n, block_req, sw_block_switch, stage_forcing_en, static_wr;
  logic [1:0] comm_ctrl_set, mag_select_set, stage_condition_q;
  logic [4:0] force_status_set;
  logic group_wr, remote_wr, inrush_en, idmt_mode, start_q, trip_q, blocked_q;
  logic [15:0] group_threshold, remote_threshold, harm_limit, harm_frac;
  logic [18:0] idmt_k, op_delay, release_time, time_to_trip_q, expected_time_q;
  logic [47:0] rms_set, true_set, peak_set, rms_o, true_o, peak_o;
  logic block_pin, block_event_q, hmi_notify_q, ev_seen, hmi_seen;
  logic [2:0] phase_start_q, phase_trip_q, event_fault_type_q;
  logic [3:0] phases_condition_q;
  logic [15:0] ratio_q, pickup_threshold_q, ev_a, ev_b, ev_c;
  int n_errors = 0;
  int n_compared = 0;
  meas_chain_model #(.REFRESH(8)) chain_u (.clk(clk), .rms_set(rms_set),
    .true_set(true_set), .peak_set(peak_set), .block_req(block_req),
    .rms_o(rms_o), .true_o(true_o), .peak_o(peak_o), .block_pin(block_pin));
  overcurrent_pickup #(.PROG_CYCLE_CLKS(8)) dut_u (.clk(clk), .rst_n(rst_n),
    .block_pin(block_pin), .sw_block_switch(sw_block_switch),
    .stage_forcing_en(stage_forcing_en), .static_wr(static_wr),
    .comm_ctrl_set(comm_ctrl_set), .force_status_set(force_status_set),
    .mag_select_set(mag_select_set), .group_wr(group_wr),
    .group_threshold(group_threshold), .remote_wr(remote_wr),
    .remote_threshold(remote_threshold), .inrush_en(inrush_en),
    .harm_limit(harm_limit), .second_harmonic_fraction(harm_frac),
    .idmt_mode(idmt_mode), .idmt_k(idmt_k), .op_delay(op_delay),
    .release_time(release_time), .phase1_rms_current(rms_o[15:0]),
    .phase2_rms_current(rms_o[31:16]), .phase3_rms_current(rms_o[47:32]),
    .phase1_true_rms_magnitude(true_o[15:0]),
    .phase2_true_rms_magnitude(true_o[31:16]),
    .phase3_true_rms_magnitude(true_o[47:32]),
    .phase1_peak_magnitude(peak_o[15:0]),
    .phase2_peak_magnitude(peak_o[31:16]),
    .phase3_peak_magnitude(peak_o[47:32]), .start_q(start_q), .trip_q(trip_q),
    .blocked_q(blocked_q), .phase_start_q(phase_start_q),
    .phase_trip_q(phase_trip_q), .stage_condition_q(stage_condition_q),
    .phases_condition_q(phases_condition_q), .time_to_trip_q(time_to_trip_q),
    .expected_time_q(expected_time_q),
    .highest_phase_to_threshold_ratio_q(ratio_q),
    .pickup_threshold_q(pickup_threshold_q), .block_event_q(block_event_q),
    .hmi_notify_q(hmi_notify_q), .event_current_a_q(ev_a),
    .event_current_b_q(ev_b), .event_current_c_q(ev_c),
    .event_fault_type_q(event_fault_type_q));
  // ****************************************
  // clock, pulse catchers, helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // pulses last one clock, so latch them for the tasks
  always @(posedge clk) begin
    if (block_event_q === 1'b1) ev_seen <= 1'b1;
    if (hmi_notify_q === 1'b1) hmi_seen <= 1'b1;
  end
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cur(input logic [15:0] a, b, c);
    rms_set = {c, b, a};
    true_set = {c, b, a};
    peak_set = {c, b, a};
    settle(64);
  endtask
  task automatic wr_static(input logic [1:0] cm, input logic [4:0] fs,
                           input logic [1:0] ms);
    comm_ctrl_set = cm;
    force_status_set = fs;
    mag_select_set = ms;
    static_wr = 1'b1;
    settle(1);
    static_wr = 1'b0;
  endtask
  task automatic wr_thr(input logic rem, input logic [15:0] v);
    group_threshold = v;
    remote_threshold = v;
    group_wr = ~rem;
    remote_wr = rem;
    settle(1);
    group_wr = 1'b0;
    remote_wr = 1'b0;
    settle(2);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_pickup;
    wr_thr(1'b0, 16'h0064);
    cur(16'h0000, 16'h0064, 16'h0000);
    `CHK(start_q, 1'b0)
    cur(16'h0000, 16'h0065, 16'h0000);
    `CHK({start_q, phase_start_q, phases_condition_q}, 8'hA2)
    `CHK(stage_condition_q, 2'h1)
    cur(16'h0000, 16'h0061, 16'h0000);
    `CHK(start_q, 1'b1)
    cur(16'h0000, 16'h0060, 16'h0000);
    `CHK(start_q, 1'b0)
  endtask
  task automatic t_magsel;
    for (int m = 1; m <= 3; m++) begin
      wr_static(2'h1, 5'h00, m[1:0]);
      rms_set = (m == 1) ? 48'h00C8 : 48'h0032;
      true_set = (m == 2) ? 48'h00C8 : 48'h0032;
      peak_set = (m == 3) ? 48'h00C8 : 48'h0032;
      settle(64);
      `CHK(start_q, 1'b1)
      cur(16'h0000, 16'h0000, 16'h0000);
    end
    wr_static(2'h1, 5'h00, 2'h1);
  endtask
  task automatic t_trip;
    op_delay = 19'h00003;
    cur(16'h00C8, 16'h00C8, 16'h00C8);
    `CHK({trip_q, phase_trip_q, phases_condition_q}, 8'hFE)
    `CHK(stage_condition_q, 2'h2)
    cur(16'h0000, 16'h0000, 16'h00C8);
    `CHK({phase_trip_q, phases_condition_q}, 7'h46)
    cur(16'h0000, 16'h0000, 16'h0000);
    `CHK(trip_q, 1'b0)
  endtask
  task automatic t_block;
    op_delay = 19'h00100;
    cur(16'h00C8, 16'h0000, 16'h0000);
    `CHK(start_q, 1'b1)
    `CHK(time_to_trip_q !== 19'h00000, 1'b1)
    ev_seen = 1'b0;
    hmi_seen = 1'b0;
    block_req = 1'b1;
    settle(64);
    `CHK({start_q, trip_q, ev_seen, hmi_seen}, 4'h3)
    `CHK({ev_a, ev_b, ev_c, event_fault_type_q}, {16'h00C8, 32'h0, 3'h1})
    cur(16'h0000, 16'h0000, 16'h0000);
    cur(16'h0000, 16'h00C8, 16'h0000);
    `CHK({start_q, blocked_q, stage_condition_q}, 4'h7)
    block_req = 1'b0;
    cur(16'h0000, 16'h0000, 16'h0000);
  endtask
  task automatic t_inrush;
    inrush_en = 1'b1;
    harm_limit = 16'h05DC;
    harm_frac = 16'h05DB;
    cur(16'h00C8, 16'h0000, 16'h0000);
    `CHK({start_q, blocked_q}, 2'h2)
    cur(16'h0000, 16'h0000, 16'h0000);
    harm_frac = 16'h05DC;
    cur(16'h00C8, 16'h0000, 16'h0000);
    `CHK({start_q, blocked_q}, 2'h1)
    inrush_en = 1'b0;
    cur(16'h0000, 16'h0000, 16'h0000);
  endtask
  task automatic t_force;
    logic [1:0] sc;
    wr_static(2'h1, 5'h02, 2'h1);
    settle(32);
    `CHK(stage_condition_q, 2'h0)
    stage_forcing_en = 1'b1;
    for (int c = 0; c <= 17; c++) begin
      wr_static(2'h1, c[4:0], 2'h1);
      settle(32);
      sc = (c <= 3) ? c[1:0] : ((c <= 6 || (c >= 10 && c <= 13)) ? 2'h1 : 2'h2);
      `CHK(stage_condition_q, sc)
      `CHK(phases_condition_q, (c >= 4) ? 4'(c - 3) : 4'h0)
    end
    wr_static(2'h1, 5'h00, 2'h1);
    sw_block_switch = 1'b1;
    cur(16'h00C8, 16'h0000, 16'h0000);
    `CHK({start_q, blocked_q}, 2'h1)
    sw_block_switch = 1'b0;
    stage_forcing_en = 1'b0;
    cur(16'h0000, 16'h0000, 16'h0000);
  endtask
  task automatic t_remote_ratio;
    wr_thr(1'b1, 16'h0200);
    `CHK(pickup_threshold_q, 16'h0064)
    wr_static(2'h2, 5'h00, 2'h1);
    wr_thr(1'b1, 16'h0200);
    `CHK(pickup_threshold_q, 16'h0200)
    wr_thr(1'b0, 16'h0064);
    idmt_mode = 1'b1;
    idmt_k = 19'h0000A;
    cur(16'h0032, 16'h00C8, 16'h0096);
    `CHK(ratio_q, 16'h00C8)
    `CHK(expected_time_q, 19'h0000A)
    idmt_mode = 1'b0;
    cur(16'h0000, 16'h0000, 16'h0000);
  endtask
  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic tally_and_finish;
    if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {rst_n, block_req, sw_block_switch, stage_forcing_en, static_wr} = '0;
    {group_wr, remote_wr, inrush_en, idmt_mode, ev_seen, hmi_seen} = '0;
    {comm_ctrl_set, force_status_set, mag_select_set} = 9'h021;
    {group_threshold, remote_threshold, harm_limit, harm_frac} = '0;
    {idmt_k, release_time} = '0;
    op_delay = 19'h00100;
    {rms_set, true_set, peak_set} = '0;
    settle(4);
    rst_n = 1'b1;
    settle(1);
    `CHK({start_q, trip_q, blocked_q, pickup_threshold_q}, 19'h00078)
    t_pickup;
    t_magsel;
    t_trip;
    t_block;
    t_inrush;
    t_force;
    t_remote_ratio;
    tally_and_finish;
  end
  // cut a hang well beyond the expected run length
  initial begin
    #(40000 * 5);
    n_errors++;
    tally_and_finish;
  end
endmodule // test_overcurrent_pickup
`default_nettype wire
